// ==== design/phy_link_dev.sv ====
// Device end: link status reporting and directed width/speed change
//
// Overview of operation
// RQ1 - Width code 00/01/10/11 is x1/x2/x4/x8
// RQ2 - Codes 0-5 for detect and polling
// RQ3 - Codes 6-A walk polling compliance substates
// RQ4 - Codes B-15 walk configuration states
// RQ5 - Codes 16-1B for L0 and L1
// RQ6 - Codes 1C-20 for recovery steps
// RQ7 - Codes 21-25 hot reset and disabled
// RQ8 - Root role uses 26-2C in configuration
// RQ9 - 2D timeout-to-detect, 2E-32 loopback
// RQ10 - Receive low-power code 00 to 11
// RQ11 - Transmit low-power code 000 to 111
// RQ12 - User sets reason: reliability 0, autonomous 1
// RQ13 - User presents reason with kind and targets
// RQ14 - Request kind is level: none/width/speed/both
// RQ15 - User starts changes only while link up
// RQ16 - Root: speed change needs auto-rate 11
// RQ17 - Target rate 0 is 2.5, 1 is 5.0
// RQ18 - User keeps rate low unless dual-rate
// RQ19 - Target lanes 00/10/11; 01 undefined
// RQ20 - Change complete flags finished directed change
// RQ21 - Dual-rate only when both ends support it
// RQ22 - User holds request until complete, then none
`timescale 1ns/100ps
module phy_link_dev
  import phy_link_pkg::*;
#(
  parameter bit         ROOT_ROLE       = 1'b0,
  parameter bit         LOCAL_DUAL_RATE = 1'b1,
  parameter logic [1:0] MAX_WIDTH       = WIDTH_X8
) (
  // Clock, reset and enable
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // User-side status and change port
  phy_link_if.dev         lnk,
  // Link-side conditions
  input  wire logic       partner_present,
  input  wire logic [1:0] partner_width,
  input  wire logic       partner_dual_rate,
  input  wire logic       compliance_req,
  input  wire logic       loopback_req,
  input  wire logic       l1_req,
  input  wire logic       hot_reset_req,
  input  wire logic       disable_req,
  input  wire logic       tx_quiet_req,
  input  wire logic       rx_partner_idle
);

  localparam int DW = $clog2(TRAIN_STEP_CYCLES + 1);
  localparam logic [DW-1:0] DWELL_LAST = DW'(TRAIN_STEP_CYCLES - 1);

  typedef struct packed {
    dev_phase_t    phase;
    logic [5:0]    code;
    logic [DW-1:0] dwell;
    logic [1:0]    width;
    logic          rate;
    logic          dual;
    logic          link_up;
    logic          done;
    logic          wchg;
    logic          schg;
    logic [1:0]    tgt_w;
    logic          tgt_r;
    logic [1:0]    rx_st;
    logic [2:0]    tx_st;
  } dev_state_t;

  dev_state_t st_reg;
  dev_state_t st_next;

  // Narrower of two width codes; codes order with lane count
  function automatic logic [1:0] narrow(input logic [1:0] a,
                                        input logic [1:0] b);
    narrow = (a < b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic       tick;
  logic [5:0] cfg_first;
  logic [5:0] nc;
  logic       want_w;
  logic       want_s;
  logic       in_l0s;

  always_comb begin
    st_next   = st_reg;
    tick      = (st_reg.dwell == DWELL_LAST);
    cfg_first = ROOT_ROLE ? TS_RP_CFG_FIRST : TS_CFG_FIRST; // RQ8
    in_l0s    = (st_reg.rx_st != RX_NOT_L0S) ||
                (st_reg.tx_st != TX_NOT_L0S);
    // RQ14 RQ19: width change only for a defined target
    want_w = lnk.change_request_kind[0] &&
             (lnk.target_lane_count != WIDTH_X2);
    // RQ17 RQ21: speed change only toward a rate both ends run
    want_s = lnk.change_request_kind[1] && st_reg.dual &&
             (lnk.target_rate_select != st_reg.rate);
    nc = st_reg.code;

    st_next.dwell = tick ? '0 : st_reg.dwell + 1'b1;

    // Training sequence, one code per dwell period
    if (tick) begin
      case (st_reg.code)
        TS_DET_QUIET0: nc = TS_DET_QUIET1;                        // RQ2
        TS_DET_QUIET1: nc = partner_present ? TS_DET_ACT0 : TS_DET_QUIET0;
        TS_DET_ACT0:   nc = TS_DET_ACT1;
        TS_DET_ACT1:   nc = partner_present ? TS_POLL_ACT : TS_DET_QUIET0;
        TS_POLL_ACT:   nc = compliance_req ? TS_COMPL_FIRST : TS_POLL_CFG;
        TS_POLL_CFG:   nc = !loopback_req ? cfg_first :
                            (ROOT_ROLE ? TS_LPBK_MASTER : TS_LPBK_ENTRY0);
        TS_COMPL_LAST: nc = TS_POLL_ACT;                           // RQ3
        TS_CFG_LN_ACC, TS_RP_LN_ACC: begin
          nc = TS_CFG_CMP_X1 + {4'h0, st_next.width};             // RQ4
        end
        TS_CFG_IDLE:   nc = TS_L0;
        TS_L0: begin                                              // RQ5
          if (hot_reset_req)
            nc = TS_HOT_RESET;
          else if (disable_req)
            nc = TS_DIS_ENTRY0;
          else if (l1_req && !in_l0s)
            nc = TS_L1_ENTRY0;
          else if (st_reg.phase == PH_CHANGE)
            nc = TS_RCV_LOCK0;
        end
        TS_L1_ENTRY2:  nc = TS_L1_IDLE;
        TS_L1_IDLE:    nc = l1_req ? TS_L1_IDLE : TS_L1_EXIT;
        TS_L1_EXIT:    nc = TS_RCV_LOCK0;
        TS_RCV_LOCK1:  nc = st_reg.schg ? TS_RCV_SPD0 : TS_RCV_IDLE; // RQ6
        TS_RCV_SPD1:   nc = TS_RCV_LOCK0;
        TS_RCV_IDLE:   nc = st_reg.wchg ? cfg_first : TS_L0;
        TS_HOT_RESET:  nc = TS_DET_QUIET0;                         // RQ7
        TS_DIS_ENTRY2: nc = TS_DIS_IDLE;
        TS_DIS_IDLE:   nc = disable_req ? TS_DIS_IDLE : TS_DET_QUIET0;
        TS_LPBK_ACT0:  nc = loopback_req ? TS_LPBK_ACT0 : TS_LPBK_EXIT0;
        TS_LPBK_EXIT0: nc = TS_DET_QUIET0;                         // RQ9
        TS_LPBK_MASTER: nc = TS_LPBK_ACT0;
        TS_TO_DETECT:  nc = TS_DET_QUIET0;
        default: begin
          // Plain single steps inside a chain
          if ((st_reg.code > TS_POLL_CFG && st_reg.code < TS_COMPL_LAST) ||
              (st_reg.code >= TS_CFG_FIRST && st_reg.code < TS_CFG_LN_ACC) ||
              (st_reg.code >= TS_RP_CFG_FIRST &&
               st_reg.code < TS_RP_LN_ACC) ||
              st_reg.code == TS_L1_ENTRY0 || st_reg.code == 6'h18 ||
              st_reg.code == TS_RCV_LOCK0 || st_reg.code == TS_RCV_SPD0 ||
              (st_reg.code >= TS_DIS_ENTRY0 &&
               st_reg.code < TS_DIS_ENTRY2) ||
              st_reg.code == TS_LPBK_ENTRY0 || st_reg.code == 6'h2f)
            nc = st_reg.code + 6'h01;
          else if (st_reg.code >= TS_CFG_CMP_X1 &&
                   st_reg.code <= TS_CFG_CMP_X8)
            nc = TS_CFG_IDLE;
          else
            nc = TS_DET_QUIET0;
        end
      endcase
    end

    // Width is settled at lane-number accept
    if (tick && (st_reg.code == TS_CFG_LN_ACC ||
                 st_reg.code == TS_RP_LN_ACC)) begin
      st_next.width = narrow(narrow(partner_width, MAX_WIDTH),
                             st_reg.wchg ? st_reg.tgt_w : MAX_WIDTH);
      st_next.wchg  = 1'b0;
      nc = TS_CFG_CMP_X1 + {4'h0, st_next.width};
    end
    if (tick && st_reg.code == TS_RCV_SPD1) begin
      st_next.rate = st_reg.tgt_r;
      st_next.schg = 1'b0;
    end

    // Losing the partner drops any trained state
    if (!partner_present && st_reg.code > TS_DET_ACT1 &&
        st_reg.code != TS_TO_DETECT) begin
      nc = TS_TO_DETECT;                                          // RQ9
      st_next.dwell = '0;
    end
    st_next.code = nc;

    // Phase and link indication
    if (nc == TS_DET_QUIET0 || nc == TS_TO_DETECT ||
        nc == TS_HOT_RESET || nc == TS_DIS_ENTRY0) begin
      st_next.phase   = PH_DOWN;
      st_next.link_up = 1'b0;
      st_next.done    = 1'b0;
      st_next.wchg    = 1'b0;
      st_next.schg    = 1'b0;
      st_next.rate    = RATE_2G5;
    end else if (nc == TS_L0 && st_reg.code != TS_L0) begin
      st_next.link_up = 1'b1;
      if (st_reg.phase == PH_CHANGE) begin
        st_next.phase = PH_DONE;
        st_next.done  = 1'b1;                                     // RQ20
      end else if (st_reg.phase == PH_DOWN) begin
        st_next.phase = PH_UP;
      end
    end else begin
      case (st_reg.phase)
        PH_UP: begin
          // RQ14: level-sensitive request, latched with its targets
          if (st_reg.code == TS_L0 && nc == TS_L0 &&
              lnk.change_request_kind != CHG_NONE) begin
            st_next.tgt_w = lnk.target_lane_count;
            st_next.tgt_r = lnk.target_rate_select;
            st_next.wchg  = want_w;
            st_next.schg  = want_s;
            if (want_w || want_s) begin
              st_next.phase = PH_CHANGE;
            end else begin
              st_next.phase = PH_DONE;
              st_next.done  = 1'b1;                               // RQ20
            end
          end
        end
        PH_DONE: begin
          if (lnk.change_request_kind == CHG_NONE) begin
            st_next.phase = PH_UP;
            st_next.done  = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // RQ21: dual rate only while both ends support it
    st_next.dual = LOCAL_DUAL_RATE && partner_dual_rate &&
                   st_next.link_up;

    // L0s sub-states, one step per cycle while in plain L0
    if (nc != TS_L0) begin
      st_next.tx_st = TX_NOT_L0S;
      st_next.rx_st = RX_NOT_L0S;
    end else begin
      case (st_reg.tx_st)                                         // RQ11
        TX_NOT_L0S:
          st_next.tx_st = (tx_quiet_req && st_reg.phase == PH_UP) ?
                          3'h1 : TX_NOT_L0S;
        TX_IDLE:
          st_next.tx_st = tx_quiet_req ? TX_IDLE : 3'h5;
        TX_FTS2:
          st_next.tx_st = TX_NOT_L0S;
        default:
          st_next.tx_st = st_reg.tx_st + 3'h1;
      endcase
      case (st_reg.rx_st)                                         // RQ10
        RX_NOT_L0S: st_next.rx_st = rx_partner_idle ? RX_ENTRY : RX_NOT_L0S;
        RX_ENTRY:   st_next.rx_st = RX_IDLE;
        RX_IDLE:    st_next.rx_st = rx_partner_idle ? RX_IDLE : RX_FTS;
        default:    st_next.rx_st = RX_NOT_L0S;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= '0;
      st_reg.phase <= PH_DOWN;
      st_reg.code  <= TS_DET_QUIET0;
      st_reg.width <= RESET_WIDTH;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from the state register
  // ----------------------------------------------------------------
  assign lnk.link_up             = st_reg.link_up;
  assign lnk.current_width_code  = st_reg.width;                  // RQ1
  assign lnk.training_state_code = st_reg.code;
  assign lnk.rx_low_power_state  = st_reg.rx_st;
  assign lnk.tx_low_power_state  = st_reg.tx_st;
  assign lnk.current_rate        = st_reg.rate;
  assign lnk.dual_rate_capable   = st_reg.dual;
  assign lnk.change_complete     = st_reg.done;

endmodule

// ==== include/phy_link_pkg.sv ====
// Shared codes, state encodings and timing for the physical-layer status port
package phy_link_pkg;

  // ----------------------------------------------------------------
  // Training state codes
  // ----------------------------------------------------------------
  localparam logic [5:0] TS_DET_QUIET0  = 6'h00;
  localparam logic [5:0] TS_DET_QUIET1  = 6'h01;
  localparam logic [5:0] TS_DET_ACT0    = 6'h02;
  localparam logic [5:0] TS_DET_ACT1    = 6'h03;
  localparam logic [5:0] TS_POLL_ACT    = 6'h04;
  localparam logic [5:0] TS_POLL_CFG    = 6'h05;
  localparam logic [5:0] TS_COMPL_FIRST = 6'h06;
  localparam logic [5:0] TS_COMPL_LAST  = 6'h0a;
  localparam logic [5:0] TS_CFG_FIRST   = 6'h0b;
  localparam logic [5:0] TS_CFG_LN_ACC  = 6'h10;
  localparam logic [5:0] TS_CFG_CMP_X1  = 6'h11;
  localparam logic [5:0] TS_CFG_CMP_X8  = 6'h14;
  localparam logic [5:0] TS_CFG_IDLE    = 6'h15;
  localparam logic [5:0] TS_L0          = 6'h16;
  localparam logic [5:0] TS_L1_ENTRY0   = 6'h17;
  localparam logic [5:0] TS_L1_ENTRY2   = 6'h19;
  localparam logic [5:0] TS_L1_IDLE     = 6'h1a;
  localparam logic [5:0] TS_L1_EXIT     = 6'h1b;
  localparam logic [5:0] TS_RCV_LOCK0   = 6'h1c;
  localparam logic [5:0] TS_RCV_LOCK1   = 6'h1d;
  localparam logic [5:0] TS_RCV_SPD0    = 6'h1e;
  localparam logic [5:0] TS_RCV_SPD1    = 6'h1f;
  localparam logic [5:0] TS_RCV_IDLE    = 6'h20;
  localparam logic [5:0] TS_HOT_RESET   = 6'h21;
  localparam logic [5:0] TS_DIS_ENTRY0  = 6'h22;
  localparam logic [5:0] TS_DIS_ENTRY2  = 6'h24;
  localparam logic [5:0] TS_DIS_IDLE    = 6'h25;
  localparam logic [5:0] TS_RP_CFG_FIRST = 6'h26;
  localparam logic [5:0] TS_RP_LN_ACC   = 6'h2c;
  localparam logic [5:0] TS_TO_DETECT   = 6'h2d;
  localparam logic [5:0] TS_LPBK_ENTRY0 = 6'h2e;
  localparam logic [5:0] TS_LPBK_ACT0   = 6'h30;
  localparam logic [5:0] TS_LPBK_EXIT0  = 6'h31;
  localparam logic [5:0] TS_LPBK_MASTER = 6'h32;

  // ----------------------------------------------------------------
  // Width, rate, low-power and request encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_X1 = 2'h0;
  localparam logic [1:0] WIDTH_X2 = 2'h1;
  localparam logic [1:0] WIDTH_X4 = 2'h2;
  localparam logic [1:0] WIDTH_X8 = 2'h3;
  localparam logic       RATE_2G5 = 1'h0;
  localparam logic       RATE_5G0 = 1'h1;
  localparam logic [1:0] RX_NOT_L0S = 2'h0;
  localparam logic [1:0] RX_ENTRY   = 2'h1;
  localparam logic [1:0] RX_IDLE    = 2'h2;
  localparam logic [1:0] RX_FTS     = 2'h3;
  localparam logic [2:0] TX_NOT_L0S = 3'h0;
  localparam logic [2:0] TX_IDLE    = 3'h4;
  localparam logic [2:0] TX_FTS2    = 3'h7;
  localparam logic [1:0] CHG_NONE   = 2'h0;
  localparam logic [1:0] CHG_WIDTH  = 2'h1;
  localparam logic [1:0] CHG_SPEED  = 2'h2;
  localparam logic [1:0] CHG_BOTH   = 2'h3;
  localparam logic       REASON_RELIABILITY = 1'h0;
  localparam logic       REASON_AUTONOMOUS  = 1'h1;
  localparam logic [1:0] AUTO_RATE_ALLOWED  = 2'h3;

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam int         TRAIN_STEP_CYCLES = 4;
  localparam logic [1:0] RESET_WIDTH = WIDTH_X1;

  // ----------------------------------------------------------------
  // Software register map of the user end
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_LINK   = 4'h8;
  localparam int CTRL_KIND_LSB  = 0;
  localparam int CTRL_RATE_BIT  = 2;
  localparam int CTRL_LANES_LSB = 3;
  localparam int CTRL_REASON_BIT = 5;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_ERR_BIT   = 2;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_DOWN   = 2'h0,
    PH_UP     = 2'h1,
    PH_CHANGE = 2'h3,
    PH_DONE   = 2'h2
  } dev_phase_t;

  typedef enum logic [1:0] {
    U_IDLE    = 2'h0,
    U_HOLD    = 2'h1,
    U_RELEASE = 2'h3
  } usr_phase_t;

endpackage

// ==== include/phy_link_if.sv ====
// Interface joining the link device end and the user logic end
`timescale 1ns/100ps
interface phy_link_if;
  logic       link_up;
  logic [1:0] current_width_code;
  logic [5:0] training_state_code;
  logic [1:0] rx_low_power_state;
  logic [2:0] tx_low_power_state;
  logic       current_rate;
  logic       dual_rate_capable;
  logic       change_complete;
  logic       change_reason_select;
  logic [1:0] change_request_kind;
  logic       target_rate_select;
  logic [1:0] target_lane_count;

  modport dev (
    output link_up, current_width_code, training_state_code,
    output rx_low_power_state, tx_low_power_state, current_rate,
    output dual_rate_capable, change_complete,
    input  change_reason_select, change_request_kind,
    input  target_rate_select, target_lane_count
  );

  modport usr (
    input  link_up, current_width_code, training_state_code,
    input  rx_low_power_state, tx_low_power_state, current_rate,
    input  dual_rate_capable, change_complete,
    output change_reason_select, change_request_kind,
    output target_rate_select, target_lane_count
  );
endinterface

// ==== design/phy_link_usr.sv ====
// User end: register-driven issuer of directed link changes
`timescale 1ns/100ps
module phy_link_usr
  import phy_link_pkg::*;
#(
  parameter bit         ROOT_ROLE           = 1'b0,
  parameter logic [1:0] root_auto_rate_attr = AUTO_RATE_ALLOWED
) (
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // Link port
  phy_link_if.usr          lnk
);

  typedef struct packed {
    usr_phase_t  phase;
    logic [1:0]  kind;
    logic        rate;
    logic [1:0]  lanes;
    logic        reason;
    logic        done;
    logic        err;
    logic [31:0] rdata;
  } usr_state_t;

  usr_state_t st_reg;
  usr_state_t st_next;

  logic [1:0] req_kind;
  logic       req_rate;

  always_comb begin
    st_next  = st_reg;
    req_kind = wdata[CTRL_KIND_LSB +: 2];
    // RQ16: root role drops speed unless auto-rate allowed
    if (ROOT_ROLE && root_auto_rate_attr != AUTO_RATE_ALLOWED)
      req_kind[1] = 1'b0;
    // RQ18: rate stays low unless both ends run dual rate
    req_rate = wdata[CTRL_RATE_BIT] && lnk.dual_rate_capable;

    // Write-one-to-clear first, so a same-cycle set below wins
    if (wr && addr == ADDR_STATUS) begin
      if (wdata[STAT_DONE_BIT])
        st_next.done = 1'b0;
      if (wdata[STAT_ERR_BIT])
        st_next.err = 1'b0;
    end

    // ----------------------------------------------------------------
    // Request sequencing
    // ----------------------------------------------------------------
    case (st_reg.phase)
      U_IDLE: begin
        if (wr && addr == ADDR_CTRL && req_kind != CHG_NONE) begin
          if (lnk.link_up) begin                                  // RQ15
            st_next.phase  = U_HOLD;
            st_next.kind   = req_kind;                            // RQ13
            st_next.rate   = req_rate;
            st_next.lanes  = wdata[CTRL_LANES_LSB +: 2];
            st_next.reason = wdata[CTRL_REASON_BIT];              // RQ12
          end else begin
            st_next.err = 1'b1;
          end
        end else if (wr && addr == ADDR_CTRL) begin
          st_next.err = st_reg.err | (wdata[CTRL_KIND_LSB +: 2] != CHG_NONE);
        end
      end
      U_HOLD: begin
        if (lnk.change_complete) begin                            // RQ22
          st_next.phase = U_RELEASE;
          st_next.kind  = CHG_NONE;
          st_next.done  = 1'b1;
        end else if (!lnk.link_up) begin
          st_next.phase = U_RELEASE;
          st_next.kind  = CHG_NONE;
          st_next.err   = 1'b1;
        end
      end
      U_RELEASE: begin
        if (!lnk.change_complete)
          st_next.phase = U_IDLE;
      end
      default: st_next.phase = U_IDLE;
    endcase

    // Busy write attempts are refused and flagged
    if (wr && addr == ADDR_CTRL && st_reg.phase != U_IDLE)
      st_next.err = 1'b1;

    // ----------------------------------------------------------------
    // Read data, valid the cycle after the strobe only
    // ----------------------------------------------------------------
    st_next.rdata = '0;
    if (rd) begin
      case (addr)
        ADDR_CTRL: st_next.rdata = {26'h0, st_reg.reason, st_reg.lanes,
                                    st_reg.rate, st_reg.kind};
        ADDR_STATUS: st_next.rdata = {26'h0, lnk.current_rate,
                                      lnk.dual_rate_capable, lnk.link_up,
                                      st_reg.err, st_reg.done,
                                      st_reg.phase != U_IDLE};
        ADDR_LINK: st_next.rdata = {19'h0, lnk.tx_low_power_state,
                                    lnk.rx_low_power_state,
                                    lnk.current_width_code,
                                    lnk.training_state_code};
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= '0;
      st_reg.phase <= U_IDLE;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign rdata                    = st_reg.rdata;
  assign lnk.change_request_kind  = st_reg.kind;                  // RQ14
  assign lnk.target_rate_select   = st_reg.rate;                  // RQ17
  assign lnk.target_lane_count    = st_reg.lanes;                 // RQ19
  assign lnk.change_reason_select = st_reg.reason;

endmodule

// ==== verif/phy_link_sva.sv ====
// Checker for the signals between the two link ends
`timescale 1ns/100ps
module phy_link_sva
  import phy_link_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Link status and request
  input wire logic       link_up,
  input wire logic [5:0] training_state_code,
  input wire logic [1:0] rx_low_power_state,
  input wire logic [2:0] tx_low_power_state,
  input wire logic       dual_rate_capable,
  input wire logic       change_complete,
  input wire logic [1:0] change_request_kind
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_UP_IN_L0: assert property ($rose(link_up)
    |-> training_state_code == TS_L0) else $error("link up off L0");
  AST_TX_IN_L0: assert property (tx_low_power_state != 3'h0
    |-> training_state_code == TS_L0) else $error("tx L0s off L0");
  AST_TX_ENTER: assert property (tx_low_power_state == 3'h1
    |=> tx_low_power_state == 3'h2 ##1 tx_low_power_state == 3'h3
    ##1 tx_low_power_state == TX_IDLE) else $error("tx entry order");
  AST_TX_EXIT: assert property (tx_low_power_state == 3'h5
    |=> tx_low_power_state == 3'h6 ##1 tx_low_power_state == TX_FTS2
    ##1 tx_low_power_state == TX_NOT_L0S) else $error("tx exit order");
  AST_RX_STEP: assert property (rx_low_power_state == RX_ENTRY
    |=> rx_low_power_state == RX_IDLE) else $error("rx entry order");
  AST_DUAL_LATE: assert property (dual_rate_capable
    |-> link_up) else $error("dual rate without link");
  AST_DONE_HOLD: assert property (change_complete &&
    change_request_kind != CHG_NONE |=> change_complete)
    else $error("complete dropped early");
  AST_DONE_CLEAR: assert property (change_complete &&
    change_request_kind == CHG_NONE |=> !change_complete)
    else $error("complete not cleared");
  AST_DONE_CAUSE: assert property ($rose(change_complete)
    |-> $past(change_request_kind) != CHG_NONE) else $error("no request");
  AST_REQ_LINK: assert property (change_request_kind != CHG_NONE &&
    $past(change_request_kind) == CHG_NONE |-> $past(link_up))
    else $error("request with link down");
  cover property ($rose(change_complete));
  cover property (tx_low_power_state == TX_IDLE);
  cover property (rx_low_power_state == RX_IDLE);
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the joined link ends
`timescale 1ns/100ps
module tb;
  import phy_link_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic        p_on = 1'b0;
  logic [1:0]  pw = WIDTH_X4;
  logic        pd = 1'b1;
  logic        quiet = 1'b0;
  logic        ridle = 1'b0;
  int          mismatches = 0;
  int          n_checks = 0;
  phy_link_if lnk ();
  always #10 clk = ~clk;
  phy_link_dev phy_link_dev_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .lnk(lnk.dev),
    .partner_present(p_on), .partner_width(pw), .partner_dual_rate(pd),
    .compliance_req(1'b0), .loopback_req(1'b0), .l1_req(1'b0),
    .hot_reset_req(1'b0), .disable_req(1'b0), .tx_quiet_req(quiet),
    .rx_partner_idle(ridle));
  phy_link_usr phy_link_usr_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .lnk(lnk.usr));
  phy_link_sva phy_link_sva_i (
    .clk(clk), .rst_n(rst_n), .link_up(lnk.link_up),
    .training_state_code(lnk.training_state_code),
    .rx_low_power_state(lnk.rx_low_power_state),
    .tx_low_power_state(lnk.tx_low_power_state),
    .dual_rate_capable(lnk.dual_rate_capable),
    .change_complete(lnk.change_complete),
    .change_request_kind(lnk.change_request_kind));
  // ------------------------------------------------------------
  // Helpers and scenarios
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic wait_for(input int s);
    int i;
    for (i = 0; i < 1000; i++) begin
      @(negedge clk);
      if ((s == 0 ? lnk.link_up : s == 1 ? lnk.change_complete
          : !lnk.change_complete) === 1'b1) break;
    end
    if (i == 1000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic train_up();
    p_on <= 1'b1;
    wait_for(0);
    chk("code", TS_L0, lnk.training_state_code);
    chk("width", WIDTH_X4, lnk.current_width_code);
    rd_reg(ADDR_STATUS, rv);
    chk("up and dual", 32'h18, rv & 32'h18);
    rd_reg(ADDR_LINK, rv);
    chk("link reg", {WIDTH_X4, TS_L0}, rv[7:0]);
    rd_reg(4'hc, rv);
    chk("unmapped", 32'h0, rv);
  endtask
  // One request, then wait only for its completion, not its release
  task automatic req(input logic r, input logic [1:0] w, k, input logic s);
    wr_reg(ADDR_CTRL, {26'h0, r, w, s, k});
    wait_for(1);
  endtask
  task automatic changes();
    req(REASON_AUTONOMOUS, WIDTH_X8, CHG_SPEED, RATE_5G0);
    chk("rate", RATE_5G0, lnk.current_rate);
    chk("width kept", WIDTH_X4, lnk.current_width_code);
    wait_for(2);
    rd_reg(ADDR_STATUS, rv);
    chk("done", 32'h2, rv & 32'h3);
    rd_reg(ADDR_CTRL, rv);
    chk("ctrl", {26'h0, REASON_AUTONOMOUS, WIDTH_X8, RATE_5G0, CHG_NONE}, rv);
    wr_reg(ADDR_CTRL, {26'h0, 1'b0, WIDTH_X1, RATE_5G0, CHG_WIDTH});
    req(1'b0, WIDTH_X8, CHG_BOTH, RATE_2G5);
    chk("width x1", WIDTH_X1, lnk.current_width_code);
    chk("rate kept", RATE_5G0, lnk.current_rate);
    wait_for(2);
    rd_reg(ADDR_STATUS, rv);
    chk("refused", 32'h4, rv & 32'h4);
    wr_reg(ADDR_STATUS, 32'h6);
    rd_reg(ADDR_STATUS, rv);
    chk("cleared", 32'h0, rv & 32'h6);
    req(REASON_RELIABILITY, 2'h1, CHG_WIDTH, RATE_5G0);
    chk("lanes 01", WIDTH_X1, lnk.current_width_code);
    wait_for(2);
  endtask
  task automatic low_power();
    @(posedge clk) quiet <= 1'b1;
    repeat (8) @(negedge clk);
    chk("tx idle", TX_IDLE, lnk.tx_low_power_state);
    @(posedge clk) quiet <= 1'b0;
    ce <= 1'b0;
    repeat (4) @(negedge clk);
    chk("frozen", TX_IDLE, lnk.tx_low_power_state);
    @(posedge clk) ce <= 1'b1;
    ridle <= 1'b1;
    repeat (8) @(negedge clk);
    chk("rx idle", RX_IDLE, lnk.rx_low_power_state);
    chk("tx out", TX_NOT_L0S, lnk.tx_low_power_state);
    @(posedge clk) ridle <= 1'b0;
    repeat (8) @(negedge clk);
    chk("rx out", RX_NOT_L0S, lnk.rx_low_power_state);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    train_up();
    changes();
    low_power();
    tally_and_finish();
  end
endmodule
